// File: design/hrxas_pkg.sv
// Constants shared by the receiver audio and video-info status bank.
// Functional notes
// R01 - Time stamp reported as 20-bit value.
// R02 - Time stamp split over 0x7B, 0x7C, 0x7D[7:4].
// R03 - Divider N reported as 20-bit value.
// R04 - Divider split over 0x7D[3:0], 0x7E, 0x7F.
// R05 - Pixel encoding in bits 6..5.
// R06 - Bit 4 flags active format present.
// R07 - Bar information in bits 3..2.
// R08 - Scan information in bits 1..0.
// R09 - Scan code 10 means underscanned content.
// R10 - Colorimetry in bits 7..6 of 0x82.
// R11 - Word length codes for 20-bit maximum.
// R12 - Word length codes for 24-bit maximum.
// R13 - Sampling frequency codes passed as received.
// R14 - Picture aspect ratio in bits 5..4.
package hrxas_pkg;

  // Bus geometry: each register index is one aligned word.
  localparam int HRXAS_ADDR_W = 12;
  localparam int HRXAS_DATA_W = 32;
  localparam int HRXAS_IDX_W = 10;
  localparam int HRXAS_WORD_LSB = 2;
  localparam int HRXAS_BYTE_W = 8;

  // Register indices; byte address is four times the index.
  localparam logic [9:0] HRXAS_IDX_SAMPLE_FREQ = 10'h061;
  localparam logic [9:0] HRXAS_IDX_WORD_LENGTH = 10'h062;
  localparam logic [9:0] HRXAS_IDX_TS_HIGH = 10'h07b;
  localparam logic [9:0] HRXAS_IDX_TS_MID = 10'h07c;
  localparam logic [9:0] HRXAS_IDX_TS_LOW_DIV_HIGH = 10'h07d;
  localparam logic [9:0] HRXAS_IDX_DIV_MID = 10'h07e;
  localparam logic [9:0] HRXAS_IDX_DIV_LOW = 10'h07f;
  localparam logic [9:0] HRXAS_IDX_VI_VERSION = 10'h080;
  localparam logic [9:0] HRXAS_IDX_VI_FORMAT = 10'h081;
  localparam logic [9:0] HRXAS_IDX_VI_COLOR_ASPECT = 10'h082;

  // Field widths.
  localparam int HRXAS_STAMP_W = 20;
  localparam int HRXAS_CODE_W = 4;
  localparam int HRXAS_FIELD_W = 2;

  // Field positions inside the 8-bit registers.
  localparam int HRXAS_CODE_LSB = 0;
  localparam int HRXAS_TS_LOW_LSB = 4;
  localparam int HRXAS_DIV_HIGH_LSB = 0;
  localparam int HRXAS_PIXEL_ENC_LSB = 5;
  localparam int HRXAS_AF_PRESENT_BIT = 4;
  localparam int HRXAS_BAR_LSB = 2;
  localparam int HRXAS_SCAN_LSB = 0;
  localparam int HRXAS_COLOR_LSB = 6;
  localparam int HRXAS_ASPECT_LSB = 4;

  // Slices of the 20-bit stamp and divider values.
  localparam int HRXAS_TS_HIGH_LSB = 12;
  localparam int HRXAS_TS_MID_LSB = 4;
  localparam int HRXAS_TS_NIB_LSB = 0;
  localparam int HRXAS_DIV_TOP_LSB = 16;
  localparam int HRXAS_DIV_MID_LSB = 8;
  localparam int HRXAS_DIV_BOT_LSB = 0;

  // Reset values.
  localparam logic [7:0] HRXAS_RESET_BYTE = 8'h00;
  localparam logic [31:0] HRXAS_RESET_WORD = 32'h0000_0000;

  // Codes as they appear in the fields (reference for software).
  localparam logic [1:0] HRXAS_PIX_RGB = 2'h0;
  localparam logic [1:0] HRXAS_PIX_YCC422 = 2'h1;
  localparam logic [1:0] HRXAS_PIX_YCC444 = 2'h2;
  localparam logic [1:0] HRXAS_SCAN_NONE = 2'h0;
  localparam logic [1:0] HRXAS_SCAN_OVER = 2'h1;
  localparam logic [1:0] HRXAS_SCAN_UNDER = 2'h2;
  localparam logic [3:0] HRXAS_WL20_NONE = 4'h0;
  localparam logic [3:0] HRXAS_WL20_16 = 4'h4;
  localparam logic [3:0] HRXAS_WL20_20 = 4'h5;
  localparam logic [3:0] HRXAS_WL24_NONE = 4'h8;
  localparam logic [3:0] HRXAS_WL24_20 = 4'hc;
  localparam logic [3:0] HRXAS_WL24_24 = 4'hd;
  localparam logic [3:0] HRXAS_SF_48K = 4'h2;
  localparam logic [3:0] HRXAS_SF_96K = 4'ha;
  localparam logic [3:0] HRXAS_SF_176K4 = 4'hc;
  localparam logic [3:0] HRXAS_SF_192K = 4'he;

endpackage

// File: design/hrxas_capture.sv
// Load-enabled holding register for one group of decoded stream values.
`timescale 1ns/10ps
module hrxas_capture #(
  parameter int W = 8
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic load, // One-cycle pulse: take d.
  input wire logic [W-1:0] d, // Value decoded from the stream.
  output logic [W-1:0] q // Held value.
);
  logic [W-1:0] next_q;

  // Hold until the decoder reports a fresh packet.
  always_comb begin
    next_q = q;
    if (load) begin
      next_q = d;
    end
  end

  // Reset to zero so an absent packet reads as no data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// File: design/hrxas_regs.sv
// Read-only APB status bank for received audio and video-info values.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module hrxas_regs #(
  parameter int ADDR_W = hrxas_pkg::HRXAS_ADDR_W
) (
  input wire logic pclk, // System clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [hrxas_pkg::HRXAS_DATA_W-1:0] pwdata, // Ignored data.
  output logic [hrxas_pkg::HRXAS_DATA_W-1:0] prdata, // Read data.
  output logic pready, // Always ready.
  output logic pslverr, // Error on write or unmapped.
  input wire logic cs_valid, // Pulse: channel status fields valid.
  input wire logic [hrxas_pkg::HRXAS_CODE_W-1:0] cs_word_length, // Code.
  input wire logic [hrxas_pkg::HRXAS_CODE_W-1:0] cs_sample_freq, // Code.
  input wire logic acr_valid, // Pulse: clock regeneration packet.
  input wire logic [hrxas_pkg::HRXAS_STAMP_W-1:0] acr_time_stamp, // Stamp.
  input wire logic [hrxas_pkg::HRXAS_STAMP_W-1:0] acr_divider, // Divider.
  input wire logic avi_valid, // Pulse: video-info frame received.
  input wire logic [hrxas_pkg::HRXAS_BYTE_W-1:0] avi_version, // Version.
  input wire logic [hrxas_pkg::HRXAS_FIELD_W-1:0] avi_pixel_encoding, // Enc.
  input wire logic avi_af_present, // Active format info valid.
  input wire logic [hrxas_pkg::HRXAS_FIELD_W-1:0] avi_bar_info, // Bars.
  input wire logic [hrxas_pkg::HRXAS_FIELD_W-1:0] avi_scan_info, // Scan.
  input wire logic [hrxas_pkg::HRXAS_FIELD_W-1:0] avi_colorimetry, // Color.
  input wire logic [hrxas_pkg::HRXAS_FIELD_W-1:0] avi_aspect // Aspect.
);
  import hrxas_pkg::*;

  localparam int CS_W = 2 * HRXAS_CODE_W;
  localparam int ACR_W = 2 * HRXAS_STAMP_W;
  localparam int AVI_W = HRXAS_BYTE_W + 5 * HRXAS_FIELD_W + 1;

  logic [CS_W-1:0] cs_held;
  logic [ACR_W-1:0] acr_held;
  logic [AVI_W-1:0] avi_held;
  logic [HRXAS_CODE_W-1:0] word_length;
  logic [HRXAS_CODE_W-1:0] sample_freq;
  logic [HRXAS_STAMP_W-1:0] time_stamp;
  logic [HRXAS_STAMP_W-1:0] divider;
  logic [HRXAS_BYTE_W-1:0] vi_version;
  logic [HRXAS_FIELD_W-1:0] pixel_enc;
  logic af_present;
  logic [HRXAS_FIELD_W-1:0] bar_info;
  logic [HRXAS_FIELD_W-1:0] scan_info;
  logic [HRXAS_FIELD_W-1:0] colorimetry;
  logic [HRXAS_FIELD_W-1:0] aspect;
  logic [HRXAS_IDX_W-1:0] idx;
  logic [HRXAS_BYTE_W-1:0] read_byte;
  logic hit;
  logic next_err;
  logic [HRXAS_DATA_W-1:0] next_prdata;

  // Codes are stored exactly as the decoder delivers them, so every
  // word-length and sampling-frequency code, legal or not, reads back.
  hrxas_capture #(
    .W(CS_W)
  ) u_cs (
    .pclk(pclk),
    .presetn(presetn),
    .load(cs_valid),
    .d({cs_word_length, cs_sample_freq}),
    .q(cs_held)
  );

  // Stamp and divider are loaded together so one packet never mixes
  // with the next; a multi-byte software read can still straddle two.
  hrxas_capture #(
    .W(ACR_W)
  ) u_acr (
    .pclk(pclk),
    .presetn(presetn),
    .load(acr_valid),
    .d({acr_time_stamp, acr_divider}), // R01 R03
    .q(acr_held)
  );

  // All video-info fields come from one frame and load as one group.
  hrxas_capture #(
    .W(AVI_W)
  ) u_avi (
    .pclk(pclk),
    .presetn(presetn),
    .load(avi_valid),
    .d({avi_version, avi_pixel_encoding, avi_af_present, avi_bar_info,
        avi_scan_info, avi_colorimetry, avi_aspect}),
    .q(avi_held)
  );

  // Unpack the held groups into named fields.
  assign {word_length, sample_freq} = cs_held;
  assign {time_stamp, divider} = acr_held;
  assign {vi_version, pixel_enc, af_present, bar_info, scan_info,
          colorimetry, aspect} = avi_held;

  // Word index of the access; the two low address bits are ignored.
  assign idx = paddr[HRXAS_WORD_LSB +: HRXAS_IDX_W];

  // Read multiplexer; unused bits of each byte read as zero.
  always_comb begin
    read_byte = HRXAS_RESET_BYTE;
    hit = 1'b1;
    unique case (idx)
      HRXAS_IDX_SAMPLE_FREQ: begin
        read_byte[HRXAS_CODE_LSB +: HRXAS_CODE_W] = sample_freq; // R13
      end
      HRXAS_IDX_WORD_LENGTH: begin
        read_byte[HRXAS_CODE_LSB +: HRXAS_CODE_W] = word_length; // R11 R12
      end
      HRXAS_IDX_TS_HIGH: begin
        read_byte = time_stamp[HRXAS_TS_HIGH_LSB +: HRXAS_BYTE_W]; // R02
      end
      HRXAS_IDX_TS_MID: begin
        read_byte = time_stamp[HRXAS_TS_MID_LSB +: HRXAS_BYTE_W]; // R02
      end
      HRXAS_IDX_TS_LOW_DIV_HIGH: begin
        read_byte[HRXAS_TS_LOW_LSB +: HRXAS_CODE_W] =
          time_stamp[HRXAS_TS_NIB_LSB +: HRXAS_CODE_W]; // R02
        read_byte[HRXAS_DIV_HIGH_LSB +: HRXAS_CODE_W] =
          divider[HRXAS_DIV_TOP_LSB +: HRXAS_CODE_W]; // R04
      end
      HRXAS_IDX_DIV_MID: begin
        read_byte = divider[HRXAS_DIV_MID_LSB +: HRXAS_BYTE_W]; // R04
      end
      HRXAS_IDX_DIV_LOW: begin
        read_byte = divider[HRXAS_DIV_BOT_LSB +: HRXAS_BYTE_W]; // R04
      end
      HRXAS_IDX_VI_VERSION: begin
        read_byte = vi_version;
      end
      HRXAS_IDX_VI_FORMAT: begin
        read_byte[HRXAS_PIXEL_ENC_LSB +: HRXAS_FIELD_W] = pixel_enc; // R05
        read_byte[HRXAS_AF_PRESENT_BIT] = af_present; // R06
        read_byte[HRXAS_BAR_LSB +: HRXAS_FIELD_W] = bar_info; // R07
        read_byte[HRXAS_SCAN_LSB +: HRXAS_FIELD_W] = scan_info; // R08 R09
      end
      HRXAS_IDX_VI_COLOR_ASPECT: begin
        read_byte[HRXAS_COLOR_LSB +: HRXAS_FIELD_W] = colorimetry; // R10
        read_byte[HRXAS_ASPECT_LSB +: HRXAS_FIELD_W] = aspect; // R14
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // The answer is sampled in the setup cycle so the access phase can
  // complete at once with registered data; writes change nothing.
  always_comb begin
    next_prdata = prdata;
    next_err = pslverr;
    if (psel && !penable) begin
      next_prdata = HRXAS_RESET_WORD;
      next_err = pwrite || !hit;
      if (hit && !pwrite) begin
        next_prdata[HRXAS_BYTE_W-1:0] = read_byte;
      end
    end
  end

  // Registered read data and error flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= HRXAS_RESET_WORD;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_err;
    end
  end

  // No wait states are ever needed.
  assign pready = 1'b1;

endmodule

// File: bench/hrxas_src_model.sv
// Behavioural stream source that hands decoded packet values to the bank.
`timescale 1ns/10ps
module hrxas_src_model (
  input wire logic pclk, // System clock.
  output logic cs_valid, // Channel status strobe.
  output logic acr_valid, // Clock regeneration strobe.
  output logic avi_valid, // Video-info strobe.
  output logic [66:0] fields // Packed field values.
);
  initial begin
    {cs_valid, acr_valid, avi_valid} = 3'h0;
    fields = '0;
  end
  // Strobes last one cycle; afterwards the lines show the inverse, so a
  // capture on the wrong edge reads garbage instead of a lucky match.
  task automatic send(input logic [2:0] which, input logic [66:0] v);
    {cs_valid, acr_valid, avi_valid} <= which;
    fields <= v;
    @(posedge pclk);
    {cs_valid, acr_valid, avi_valid} <= 3'h0;
    fields <= ~v;
  endtask
endmodule

// File: bench/hrxas_regs_chk.sv
// Checker for the audio and video-info status bank.
`timescale 1ns/10ps
module hrxas_regs_chk (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // Bus select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Direction, high for write.
  input wire logic [11:0] paddr, // Byte address.
  input wire logic [31:0] pwdata, // Write data, ignored by the bank.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error response.
  input wire logic cs_valid, // Channel status strobe.
  input wire logic acr_valid, // Clock regeneration strobe.
  input wire logic avi_valid, // Video-info strobe.
  input wire logic [3:0] cs_word_length, // Word length code.
  input wire logic [3:0] cs_sample_freq, // Sampling frequency code.
  input wire logic [19:0] acr_time_stamp, // Time stamp.
  input wire logic [19:0] acr_divider, // Divider.
  input wire logic [7:0] avi_version, // Version.
  input wire logic avi_af_present, // Format flag.
  input wire logic [1:0] avi_pixel_encoding, // Pixel encoding.
  input wire logic [1:0] avi_bar_info, // Bar information.
  input wire logic [1:0] avi_scan_info, // Scan information.
  input wire logic [1:0] avi_colorimetry, // Colorimetry.
  input wire logic [1:0] avi_aspect // Picture aspect.
);
  import hrxas_pkg::*;
  logic [66:0] sh, next_sh;
  // Own copy of the held groups, loaded on the same strobes as the bank.
  always_comb begin
    next_sh = sh;
    if (cs_valid) next_sh[66:59] = {cs_word_length, cs_sample_freq};
    if (acr_valid) next_sh[58:19] = {acr_time_stamp, acr_divider};
    if (avi_valid) next_sh[18:0] = {avi_version, avi_pixel_encoding,
      avi_af_present, avi_bar_info, avi_scan_info, avi_colorimetry, avi_aspect};
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sh <= '0;
    else sh <= next_sh;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read data is fixed at the setup edge, so it reflects the copy before it.
  sequence rd_s(logic [9:0] a);
    psel && penable && !pwrite && paddr[11:2] == a;
  endsequence
  stamp_high_a: assert property (
    rd_s(HRXAS_IDX_TS_HIGH) |-> prdata == {24'h0, $past(sh[58:51])})
    else $error("stamp high byte wrong");
  stamp_mid_a: assert property (
    rd_s(HRXAS_IDX_TS_MID) |-> prdata == {24'h0, $past(sh[50:43])})
    else $error("stamp mid byte wrong");
  shared_nibble_a: assert property (
    rd_s(HRXAS_IDX_TS_LOW_DIV_HIGH) |-> prdata == {24'h0, $past(sh[42:35])})
    else $error("shared nibble byte wrong");
  divider_mid_a: assert property (
    rd_s(HRXAS_IDX_DIV_MID) |-> prdata == {24'h0, $past(sh[34:27])})
    else $error("divider mid byte wrong");
  divider_low_a: assert property (
    rd_s(HRXAS_IDX_DIV_LOW) |-> prdata == {24'h0, $past(sh[26:19])})
    else $error("divider low byte wrong");
  word_length_a: assert property (
    rd_s(HRXAS_IDX_WORD_LENGTH) |-> prdata == {28'h0, $past(sh[66:63])})
    else $error("word length wrong");
  sample_freq_a: assert property (
    rd_s(HRXAS_IDX_SAMPLE_FREQ) |-> prdata == {28'h0, $past(sh[62:59])})
    else $error("sampling code wrong");
  video_format_a: assert property (
    rd_s(HRXAS_IDX_VI_FORMAT) |-> prdata == {25'h0, $past(sh[10:4])})
    else $error("video format byte wrong");
  color_aspect_a: assert property (
    rd_s(HRXAS_IDX_VI_COLOR_ASPECT) |->
      prdata == {24'h0, $past(sh[3:0]), 4'h0})
    else $error("color aspect byte wrong");
  // The version byte has no field packing, so a whole-byte compare.
  version_byte_a: assert property (
    rd_s(HRXAS_IDX_VI_VERSION) |-> prdata == {24'h0, $past(sh[18:11])})
    else $error("version byte wrong");
  write_refused_a: assert property (
    psel && penable && pwrite |-> pslverr && prdata == 32'h0)
    else $error("write not refused");
endmodule
bind hrxas_regs hrxas_regs_chk chk_u (.*);

// File: bench/tb_top.sv
// Self-checking bench for the audio and video-info status bank.
`timescale 1ns/10ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  wire cs_valid, acr_valid, avi_valid;
  wire [66:0] fields;
  wire [3:0] cs_word_length, cs_sample_freq;
  wire [19:0] acr_time_stamp, acr_divider;
  wire [7:0] avi_version;
  wire avi_af_present;
  wire [1:0] avi_pixel_encoding, avi_bar_info, avi_scan_info;
  wire [1:0] avi_colorimetry, avi_aspect;
  logic [66:0] held, v;
  logic [32:0] q [$];
  logic [9:0] map [14] = '{10'h061, 10'h062, 10'h07b, 10'h07c, 10'h07d,
    10'h07e, 10'h07f, 10'h080, 10'h081, 10'h082, 10'h000, 10'h060, 10'h083,
    10'h3ff};
  int miscompares = 0, n_tests = 0, cycles = 0;
  assign {cs_word_length, cs_sample_freq, acr_time_stamp, acr_divider,
    avi_version, avi_pixel_encoding, avi_af_present, avi_bar_info,
    avi_scan_info, avi_colorimetry, avi_aspect} = fields;
  hrxas_src_model src_u (.pclk, .cs_valid, .acr_valid, .avi_valid, .fields);
  hrxas_regs dut_u (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Expected {error, data}; writes and holes answer with an error.
  function automatic logic [32:0] exp_of(input logic w, input logic [9:0] i);
    if (w) return {1'b1, 32'h0};
    case (i)
      10'h061: return {29'h0, held[62:59]};
      10'h062: return {29'h0, held[66:63]};
      10'h07b: return {25'h0, held[58:51]};
      10'h07c: return {25'h0, held[50:43]};
      10'h07d: return {25'h0, held[42:35]};
      10'h07e: return {25'h0, held[34:27]};
      10'h07f: return {25'h0, held[26:19]};
      10'h080: return {25'h0, held[18:11]};
      10'h081: return {26'h0, held[10:4]};
      10'h082: return {25'h0, held[3:0], 4'h0};
      default: return {1'b1, 32'h0};
    endcase
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One transfer; psel stays up so the next setup may follow at once.
  task automatic apb(input logic w, input logic [9:0] i);
    q.push_back(exp_of(w, i));
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= $urandom;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    penable <= 1'b0;
  endtask
  task automatic sweep();
    foreach (map[j]) apb(1'b0, map[j]);
    psel <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pkt(input logic [2:0] w, input logic [66:0] x);
    src_u.send(w, x);
    if (w[2]) held[66:59] = x[66:59];
    if (w[1]) held[58:19] = x[58:19];
    if (w[0]) held[18:0] = x[18:0];
  endtask
  // Results are compared as the access phase completes.
  always @(posedge pclk)
    if (psel && penable && pready)
      check({pslverr, prdata}, q.pop_front());
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = '0;
    pwdata = '0;
    held = '0;
    void'($urandom(32'h1c1077f6));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sweep();
    $display("reset values test done");
    // Every code of word length, sampling, bar and aspect; codes 0 to 2 only of encoding, scan and colorimetry; random wide values.
    for (int k = 0; k < 16; k++) begin
      v = {$urandom, $urandom, $urandom} >> 29;
      v[66:63] = k[3:0];
      v[62:59] = 4'(15 - k);
      v[10:4] = {2'(k % 3), k[0], k[1:0], 2'(k % 3)};
      v[3:0] = {2'(k % 3), k[1:0]};
      pkt(3'h7, v);
      sweep();
    end
    $display("code table test done");
    // Single groups only; the others must keep their values.
    for (int k = 0; k < 8; k++) begin
      pkt(3'(1 << (k % 3)), {$urandom, $urandom, $urandom} >> 29);
      sweep();
    end
    $display("partial update test done");
    apb(1'b1, 10'h081);
    apb(1'b1, 10'h07b);
    sweep();
    $display("write refusal test done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    held = '0;
    @(posedge pclk);
    sweep();
    $display("second reset test done");
    test_done();
  end
endmodule
